// File: rtl/cop_defs.svh
// register map, field positions, reset values and timing constants of the output protection block
`ifndef COP_DEFS_SVH
`define COP_DEFS_SVH

// register byte offsets
`define COP_OFF_CHAN_EN 8'h20
`define COP_OFF_COMMON 8'h44
`define COP_OFF_STATUS 8'h48
`define COP_OFF_FP1 8'h80
`define COP_OFF_FP2 8'h84
`define COP_OFF_FP3 8'h88
`define COP_OFF_BRK 8'h8c

// free-protection and common protection fields
`define COP_FP_SEL 31
`define COP_FP_ROS 11
`define COP_FP_IOS 10
`define COP_DT_MSB 7
`define COP_DT_LSB 0
`define COP_CM_LOCK_MSB 9
`define COP_CM_LOCK_LSB 8
`define COP_CM_BRKPOL 13
`define COP_CM_MOE 15
`define COP_LOCK_OPEN 2'h0

// break source configuration fields
`define COP_BRK_CMP1_INV 26
`define COP_BRK_CMP0_INV 25
`define COP_BRK_PIN2_INV 18
`define COP_BRK_PIN1_INV 17
`define COP_BRK_PIN0_INV 16
`define COP_BRK_CMP1_EN 10
`define COP_BRK_CMP0_EN 9
`define COP_BRK_FILT_EN 8
`define COP_BRK_PIN2_EN 2
`define COP_BRK_PIN1_EN 1
`define COP_BRK_PIN0_EN 0
`define COP_BRK_RESET 32'h0000_0007

// dead-time code bases and step shifts
`define COP_DT_BASE_MID 11'h040
`define COP_DT_BASE_HI 11'h020
`define COP_DT_SH_MID 1
`define COP_DT_SH_HI8 3
`define COP_DT_SH_HI16 4

// dead-time sample period in ns, and its clock cycles at 250 MHz (rounded up)
`define COP_CLK_MHZ 250
`define COP_DTS_PERIOD_NS 4
`define COP_DTS_CYCLES ((`COP_DTS_PERIOD_NS * `COP_CLK_MHZ + 999) / 1000)

`endif

// File: rtl/cop_pkg.sv
// types shared by the output protection block
package cop_pkg;

    // one set of protection settings for a channel pair
    typedef struct packed {
        logic sel;
        logic run_offstate_en;
        logic idle_offstate_en;
        logic [7:0] dt;
    } cop_pair_cfg_type;

    // drive of one complementary pair towards the gate drivers
    typedef struct packed {
        logic direct_out;
        logic direct_oe;
        logic compl_out;
        logic compl_oe;
    } cop_pair_out_type;

    // break source selection and polarity
    typedef struct packed {
        logic [1:0] cmp_inv;
        logic [2:0] pin_inv;
        logic [1:0] cmp_en;
        logic filt_en;
        logic [2:0] pin_en;
    } cop_break_cfg_type;

    // raw break source levels
    typedef struct packed {
        logic [2:0] pin;
        logic [1:0] cmp;
        logic filt;
    } cop_break_src_type;

endpackage

// File: rtl/cop_deadtime.sv
// dead-time generator for one complementary pair
`include "cop_defs.svh"

module cop_deadtime (
    input logic clk,
    input logic resetn,
    input logic ref_in,
    input logic [7:0] dead_time_setting,
    output logic direct_on,
    output logic compl_on
);
    import cop_pkg::*;

    logic ref_q;
    logic [10:0] cnt;
    logic [10:0] next_cnt;

    // code to clock cycles, by range of the top three bits
    function automatic logic [10:0] dt_cycles(input logic [7:0] s);
        logic [10:0] u;
        if (!s[7]) begin
            u = {3'h0, s}; // [RL7]
        end else if (!s[6]) begin
            u = 11'((`COP_DT_BASE_MID + {5'h00, s[5:0]}) << `COP_DT_SH_MID); // [RL8]
        end else if (!s[5]) begin
            u = 11'((`COP_DT_BASE_HI + {6'h00, s[4:0]}) << `COP_DT_SH_HI8); // [RL9]
        end else begin
            u = 11'((`COP_DT_BASE_HI + {6'h00, s[4:0]}) << `COP_DT_SH_HI16); // [RL10]
        end
        return 11'(u * `COP_DTS_CYCLES);
    endfunction

    // each edge of the reference restarts the gap; both sides stay off until it ends
    assign next_cnt = (ref_in != ref_q) ? dt_cycles(dead_time_setting) : ((cnt != 11'h000) ? cnt - 11'h001 : cnt);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ref_q <= 1'b0;
            cnt <= 11'h000;
        end else begin
            ref_q <= ref_in;
            cnt <= next_cnt; // [RL6]
        end
    end

    // outputs turn on only once the gap count has run out
    always_ff @(posedge clk) begin
        if (!resetn) begin
            direct_on <= 1'b0;
            compl_on <= 1'b0;
        end else begin
            direct_on <= ref_in && (next_cnt == 11'h000);
            compl_on <= !ref_in && (next_cnt == 11'h000);
        end
    end

    a_dt_exclusive: assert property (@(posedge clk) disable iff (!resetn) !(direct_on && compl_on)) // [RL6]
        else $error("both sides of the pair on at once");
    a_dt_gap_start: assert property (@(posedge clk) disable iff (!resetn) // [RL6]
        (ref_in != ref_q) && (dead_time_setting != 8'h00) |=> !direct_on && !compl_on)
        else $error("no gap after reference edge");
endmodule

// File: rtl/cop_break_merge.sv
// first break request from polarity-adjusted enabled sources
`include "cop_defs.svh"

module cop_break_merge (
    input logic clk,
    input logic resetn,
    input cop_pkg::cop_break_cfg_type cfg,
    input logic first_break_polarity,
    input cop_pkg::cop_break_src_type src,
    output logic break_request
);
    import cop_pkg::*;

    logic [2:0] pin_act;
    logic [1:0] cmp_act;
    logic next_break;

    // uninverted source is active at the global polarity level, the invert bit flips that
    assign pin_act = ~(src.pin ^ cfg.pin_inv ^ {3{first_break_polarity}}); // [RL14]
    assign cmp_act = ~(src.cmp ^ cfg.cmp_inv ^ {2{first_break_polarity}}); // [RL14]

    // any enabled active source raises the request; filter unit level is taken as active high
    assign next_break = |(pin_act & cfg.pin_en) | |(cmp_act & cfg.cmp_en) | (src.filt & cfg.filt_en); // [RL21]

    always_ff @(posedge clk) begin
        if (!resetn) begin
            break_request <= 1'b0;
        end else begin
            break_request <= next_break; // [RL21]
        end
    end

    a_break_any: assert property (@(posedge clk) disable iff (!resetn) // [RL21]
        (cfg.pin_en[0] && (src.pin[0] == first_break_polarity) && !cfg.pin_inv[0]) |=> break_request)
        else $error("enabled break pin did not raise request");
    a_break_none: assert property (@(posedge clk) disable iff (!resetn) // [RL17]
        (cfg.pin_en == 3'h0 && cfg.cmp_en == 2'h0 && !cfg.filt_en) |=> !break_request)
        else $error("request raised with all sources disabled");
endmodule

// File: rtl/cop_top.sv
// complementary output protection settings and first break source configuration
//
// Summary of operation
// RL1: private select picks channel register over common
// RL2: select and dead time writable only unlocked
// RL3: run mode: disabled side off-state or released
// RL4: idle mode: off-state both, else release only the disabled sides
// RL5: off-state bits frozen at lock levels 10/11
// RL6: dead time inserted before each pair transition
// RL7: code 0xx: value times sample period
// RL8: code 10x: (64+low6) times two periods
// RL9: code 110: (32+low5) times eight periods
// RL10: code 111: (32+low5) times sixteen periods
// RL11: 0x84 serves channel 2, 0x88 channel 3
// RL12: software uses whole word accesses only
// RL13: software writes reserved bits as reset value
// RL14: invert bit flips source against global polarity
// RL15: pin invert bits sit at 18..16
// RL16: comparator invert bits at 25 and 26
// RL17: comparator enables at bits 10 and 9
// RL18: break configuration writable only when unlocked
// RL19: break configuration resets to 0x0000_0007
// RL20: pin enables bits 2..0, filter bit 8
// RL21: any enabled active source raises break
`include "cop_defs.svh"

module cop_top (
    input logic clk,
    input logic resetn,
    input logic [7:0] addr,
    input logic [31:0] wdata,
    input logic wr,
    input logic rd,
    output logic [31:0] rdata,
    input logic [2:0] pwm_ref,
    input cop_pkg::cop_break_src_type break_src,
    output cop_pkg::cop_pair_out_type [2:0] pair_out,
    output logic break_request
);
    import cop_pkg::*;

    // register state
    cop_pair_cfg_type common;
    logic [1:0] lock_level;
    logic main_out_enable;
    logic first_break_polarity;
    cop_pair_cfg_type fp [3];
    logic [5:0] chan_enable;
    cop_break_cfg_type brk;

    // derived state
    cop_pair_cfg_type sel_cfg [3];
    logic [2:0] direct_on;
    logic [2:0] compl_on;
    logic [31:0] next_rdata;
    logic unlocked;
    logic wr_common;
    logic wr_chan_en;
    logic wr_brk;
    logic [2:0] wr_fp;

    // settings word written under lock: select and dead time need lock 00, off-state bits need lock below 10
    function automatic cop_pair_cfg_type fp_write(input cop_pair_cfg_type old, input logic [31:0] w,
                                                  input logic [1:0] lock);
        cop_pair_cfg_type n;
        n = old;
        if (lock == `COP_LOCK_OPEN) begin
            n.sel = w[`COP_FP_SEL]; // [RL2]
            n.dt = w[`COP_DT_MSB:`COP_DT_LSB]; // [RL2]
        end
        if (!lock[1]) begin
            n.run_offstate_en = w[`COP_FP_ROS]; // [RL5]
            n.idle_offstate_en = w[`COP_FP_IOS]; // [RL5]
        end
        return n;
    endfunction

    // settings to bus word; reserved bits read as zero
    function automatic logic [31:0] fp_word(input cop_pair_cfg_type c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`COP_FP_SEL] = c.sel;
        w[`COP_FP_ROS] = c.run_offstate_en;
        w[`COP_FP_IOS] = c.idle_offstate_en;
        w[`COP_DT_MSB:`COP_DT_LSB] = c.dt;
        return w;
    endfunction

    // break configuration to bus word
    function automatic logic [31:0] brk_word(input cop_break_cfg_type b);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`COP_BRK_CMP1_INV] = b.cmp_inv[1]; // [RL16]
        w[`COP_BRK_CMP0_INV] = b.cmp_inv[0]; // [RL16]
        w[`COP_BRK_PIN2_INV] = b.pin_inv[2]; // [RL15]
        w[`COP_BRK_PIN1_INV] = b.pin_inv[1]; // [RL15]
        w[`COP_BRK_PIN0_INV] = b.pin_inv[0]; // [RL15]
        w[`COP_BRK_CMP1_EN] = b.cmp_en[1]; // [RL17]
        w[`COP_BRK_CMP0_EN] = b.cmp_en[0]; // [RL17]
        w[`COP_BRK_FILT_EN] = b.filt_en; // [RL20]
        w[`COP_BRK_PIN2_EN] = b.pin_en[2]; // [RL20]
        w[`COP_BRK_PIN1_EN] = b.pin_en[1]; // [RL20]
        w[`COP_BRK_PIN0_EN] = b.pin_en[0]; // [RL20]
        return w;
    endfunction

    // bus word to break configuration
    function automatic cop_break_cfg_type brk_unpack(input logic [31:0] w);
        cop_break_cfg_type b;
        b.cmp_inv = {w[`COP_BRK_CMP1_INV], w[`COP_BRK_CMP0_INV]}; // [RL16]
        b.pin_inv = {w[`COP_BRK_PIN2_INV], w[`COP_BRK_PIN1_INV], w[`COP_BRK_PIN0_INV]}; // [RL15]
        b.cmp_en = {w[`COP_BRK_CMP1_EN], w[`COP_BRK_CMP0_EN]}; // [RL17]
        b.filt_en = w[`COP_BRK_FILT_EN]; // [RL20]
        b.pin_en = {w[`COP_BRK_PIN2_EN], w[`COP_BRK_PIN1_EN], w[`COP_BRK_PIN0_EN]}; // [RL20]
        return b;
    endfunction

    // address decode; the bus never waits
    assign unlocked = (lock_level == `COP_LOCK_OPEN);
    assign wr_common = wr && (addr == `COP_OFF_COMMON);
    assign wr_chan_en = wr && (addr == `COP_OFF_CHAN_EN);
    assign wr_brk = wr && (addr == `COP_OFF_BRK);
    assign wr_fp[0] = wr && (addr == `COP_OFF_FP1);
    assign wr_fp[1] = wr && (addr == `COP_OFF_FP2); // [RL11]
    assign wr_fp[2] = wr && (addr == `COP_OFF_FP3); // [RL11]

    // common protection settings; lock level can only be raised from open, then holds until reset
    always_ff @(posedge clk) begin
        if (!resetn) begin
            common <= '0;
            lock_level <= `COP_LOCK_OPEN;
            main_out_enable <= 1'b0;
            first_break_polarity <= 1'b0;
        end else if (wr_common) begin
            common <= fp_write(common, wdata, lock_level);
            main_out_enable <= wdata[`COP_CM_MOE];
            if (unlocked) begin
                lock_level <= wdata[`COP_CM_LOCK_MSB:`COP_CM_LOCK_LSB];
                first_break_polarity <= wdata[`COP_CM_BRKPOL];
            end
        end
    end

    // per-channel private settings
    always_ff @(posedge clk) begin
        if (!resetn) begin
            for (int i = 0; i < 3; i++) begin
                fp[i] <= '0;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (wr_fp[i]) begin
                    fp[i] <= fp_write(fp[i], wdata, lock_level); // [RL2] [RL5]
                end
            end
        end
    end

    // direct and complementary enables of the three pairs, never locked
    always_ff @(posedge clk) begin
        if (!resetn) begin
            chan_enable <= 6'h00;
        end else if (wr_chan_en) begin
            chan_enable <= wdata[5:0];
        end
    end

    // break source configuration; a locked write is dropped whole
    always_ff @(posedge clk) begin
        if (!resetn) begin
            brk <= brk_unpack(`COP_BRK_RESET); // [RL19]
        end else if (wr_brk && unlocked) begin
            brk <= brk_unpack(wdata); // [RL18]
        end
    end

    // settings in force per pair: private register when selected, else the common one
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            sel_cfg[i] = fp[i].sel ? fp[i] : common; // [RL1]
        end
    end

    // read data one cycle after the strobe; unmapped offsets and idle cycles read zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (rd) begin
            unique case (addr)
                `COP_OFF_COMMON: begin
                    next_rdata = fp_word(common);
                    next_rdata[`COP_FP_SEL] = 1'b0;
                    next_rdata[`COP_CM_LOCK_MSB:`COP_CM_LOCK_LSB] = lock_level;
                    next_rdata[`COP_CM_BRKPOL] = first_break_polarity;
                    next_rdata[`COP_CM_MOE] = main_out_enable;
                end
                `COP_OFF_CHAN_EN: next_rdata[5:0] = chan_enable;
                `COP_OFF_STATUS: next_rdata[3:0] = {fp[2].sel, fp[1].sel, fp[0].sel, break_request};
                `COP_OFF_FP1: next_rdata = fp_word(fp[0]);
                `COP_OFF_FP2: next_rdata = fp_word(fp[1]); // [RL11]
                `COP_OFF_FP3: next_rdata = fp_word(fp[2]); // [RL11]
                `COP_OFF_BRK: next_rdata = brk_word(brk);
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdata <= 32'h0000_0000;
        end else begin
            rdata <= next_rdata;
        end
    end

    // dead-time generators, one per pair, fed from the settings in force
    for (genvar g = 0; g < 3; g++) begin : g_pair
        cop_deadtime u_dt (
            .clk(clk),
            .resetn(resetn),
            .ref_in(pwm_ref[g]),
            .dead_time_setting(sel_cfg[g].dt), // [RL6]
            .direct_on(direct_on[g]),
            .compl_on(compl_on[g])
        );
    end

    // output stage; off-state is the low level with the pin driven, disabled means released
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pair_out <= '0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (main_out_enable) begin
                    // run mode: enabled side follows the dead-time generator
                    pair_out[i].direct_out <= chan_enable[2 * i] && direct_on[i];
                    pair_out[i].direct_oe <= chan_enable[2 * i] || sel_cfg[i].run_offstate_en; // [RL3]
                    pair_out[i].compl_out <= chan_enable[2 * i + 1] && compl_on[i];
                    pair_out[i].compl_oe <= chan_enable[2 * i + 1] || sel_cfg[i].run_offstate_en; // [RL3]
                end else begin
                    // idle mode: never drives an active level
                    pair_out[i].direct_out <= 1'b0;
                    pair_out[i].compl_out <= 1'b0;
                    pair_out[i].direct_oe <= sel_cfg[i].idle_offstate_en || chan_enable[2 * i]; // [RL4]
                    pair_out[i].compl_oe <= sel_cfg[i].idle_offstate_en || chan_enable[2 * i + 1]; // [RL4]
                end
            end
        end
    end

    // first break function
    cop_break_merge u_brk (
        .clk(clk),
        .resetn(resetn),
        .cfg(brk),
        .first_break_polarity(first_break_polarity),
        .src(break_src),
        .break_request(break_request)
    );

    a_lock_sel_hold: assert property (@(posedge clk) disable iff (!resetn) // [RL2]
        wr_fp[1] && !unlocked |=> fp[1].sel == $past(fp[1].sel) && fp[1].dt == $past(fp[1].dt))
        else $error("select or dead time changed while locked");
    a_lock_sel_take: assert property (@(posedge clk) disable iff (!resetn) // [RL2]
        wr_fp[2] && unlocked |=> fp[2].dt == $past(wdata[7:0]) && fp[2].sel == $past(wdata[31]))
        else $error("unlocked write not taken");
    a_offstate_lock: assert property (@(posedge clk) disable iff (!resetn) // [RL5]
        wr_fp[2] && lock_level[1] |=> $stable(fp[2].run_offstate_en) && $stable(fp[2].idle_offstate_en))
        else $error("off-state bits changed at high lock level");
    a_brk_lock_hold: assert property (@(posedge clk) disable iff (!resetn) // [RL18]
        wr_brk && !unlocked |=> $stable(brk))
        else $error("break configuration changed while locked");
    a_brk_reset_val: assert property (@(posedge clk) // [RL19]
        !resetn |=> brk_word(brk) == `COP_BRK_RESET)
        else $error("break configuration reset value wrong");
    a_sel_private: assert property (@(posedge clk) disable iff (!resetn) // [RL1]
        wr_fp[1] && unlocked && wdata[31] |=> sel_cfg[1].dt == fp[1].dt ##1 fp[1].sel)
        else $error("private settings not in force");
    a_run_release: assert property (@(posedge clk) disable iff (!resetn) // [RL3]
        main_out_enable && !chan_enable[0] && !sel_cfg[0].run_offstate_en |=> !pair_out[0].direct_oe)
        else $error("disabled run output still driven");
    a_run_offstate: assert property (@(posedge clk) disable iff (!resetn) // [RL3]
        main_out_enable && !chan_enable[3] && sel_cfg[1].run_offstate_en |=> pair_out[1].compl_oe && !pair_out[1].compl_out)
        else $error("run off-state not driven");
    a_idle_offstate: assert property (@(posedge clk) disable iff (!resetn) // [RL4]
        !main_out_enable && sel_cfg[1].idle_offstate_en |=> pair_out[1].direct_oe && pair_out[1].compl_oe
        && !pair_out[1].direct_out && !pair_out[1].compl_out)
        else $error("idle off-state not applied to both outputs");
    a_idle_release: assert property (@(posedge clk) disable iff (!resetn) // [RL4]
        !main_out_enable && !sel_cfg[1].idle_offstate_en && chan_enable[3:2] == 2'h0 |=> !pair_out[1].direct_oe && !pair_out[1].compl_oe)
        else $error("idle outputs not released");
    a_read_fp2: assert property (@(posedge clk) disable iff (!resetn) // [RL11]
        rd && addr == `COP_OFF_FP2 |=> rdata == fp_word($past(fp[1])))
        else $error("channel 2 register read wrong");
endmodule

// File: verif/cop_gate_model.sv
// gate driver and break fault source model facing the protection block
module cop_gate_model (
    input logic clk,
    input cop_pkg::cop_pair_out_type [2:0] pair_out,
    input logic [5:0] fault_level,
    output cop_pkg::cop_break_src_type break_src,
    output logic shoot_through
);
    import cop_pkg::*;

    // fault lines start quiet and settle one clock after the bench asks
    initial begin
        break_src = '0;
        shoot_through = 1'b0;
    end
    always @(posedge clk) begin
        break_src <= cop_break_src_type'(fault_level);
    end

    // both switches of a leg on together would short the supply
    always @(posedge clk) begin
        for (int i = 0; i < 3; i++) begin
            if (pair_out[i].direct_oe && pair_out[i].compl_oe && pair_out[i].direct_out && pair_out[i].compl_out) begin
                shoot_through <= 1'b1;
            end
        end
    end
endmodule

// File: verif/tb.sv
// self-checking bench for the output protection block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cop_pkg::*;

    typedef struct packed {
        logic [1:0] kind;
        logic [31:0] val;
    } cop_exp_type;

    logic clk;
    logic resetn;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic [2:0] pwm_ref;
    cop_break_src_type break_src;
    cop_pair_out_type [2:0] pair_out;
    logic break_request;
    logic [5:0] fault_level;
    logic shoot_through;
    logic rd_q;
    logic look;
    logic [31:0] meas;
    cop_exp_type exp_q[$];
    int failures;
    int total_checks;
    logic [7:0] codes[5] = '{8'h00, 8'h05, 8'h81, 8'hc2, 8'he1};
    logic [8:0] md[5] = '{9'b1_0110_0101, 9'b1_0100_0100, 9'b0_0001_0101, 9'b0_0000_0000, 9'b0_1000_0001};
    int en_pos[6] = '{0, 1, 2, 8, 9, 10};
    int inv_pos[6] = '{16, 17, 18, 16, 25, 26};
    int src_bit[6] = '{3, 4, 5, 0, 1, 2};

    cop_top DUT (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .pwm_ref(pwm_ref), .break_src(break_src), .pair_out(pair_out), .break_request(break_request));

    cop_gate_model gates (.clk(clk), .pair_out(pair_out), .fault_level(fault_level), .break_src(break_src),
        .shoot_through(shoot_through));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // oldest note is matched to the result showing in this cycle
    always @(posedge clk) begin
        cop_exp_type e;
        if (rd_q || look) begin
            e = exp_q.pop_front();
            case (e.kind)
                2'd0: check("rdata", rdata, e.val);
                2'd1: check("pair_out", {27'h0, shoot_through, pair_out[1]}, e.val);
                2'd2: check("break_request", {30'h0, shoot_through, break_request}, e.val);
                default: check("dead_time", meas, e.val);
            endcase
        end
        rd_q <= rd;
    end

    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1; // whole words only, no byte lanes
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd32(input logic [7:0] a, input logic [31:0] want);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back({2'd0, want});
        @(posedge clk);
        rd <= 1'b0;
    endtask

    // one-cycle look at the outputs, judged by the watcher
    task automatic probe(input logic [1:0] k, input logic [31:0] want);
        @(posedge clk);
        exp_q.push_back({k, want});
        look <= 1'b1;
        @(posedge clk);
        look <= 1'b0;
    endtask

    task automatic do_reset();
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
    endtask

    function automatic logic [31:0] cm(input logic moe, input logic pol, input logic [1:0] lk, input logic [7:0] dt);
        return {16'h0, moe, 1'b0, pol, 3'h0, lk, dt};
    endfunction

    // reserved bits always written as zero
    function automatic logic [31:0] fp(input logic sel, input logic run_offstate_en, input logic idle_offstate_en, input logic [7:0] dt);
        return {sel, 19'h0, run_offstate_en, idle_offstate_en, 2'h0, dt};
    endfunction

    function automatic int dt_len(input logic [7:0] c);
        casez (c[7:5])
            3'b0??: return 32'(c);
            3'b10?: return (64 + c[5:0]) * 2;
            3'b110: return (32 + c[4:0]) * 8;
            default: return (32 + c[4:0]) * 16;
        endcase
    endfunction

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // hang guard, well beyond the longest dead-time sweep
    initial begin
        repeat (30000) @(posedge clk);
        failures++;
        complete_run();
    end

    initial begin
        int n;
        logic [7:0] dt;
        logic inv;
        logic pol;
        logic lvl;
        logic [31:0] cfg;
        logic [5:0] noise;
        resetn = 1'b0;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        wr = 1'b0;
        rd = 1'b0;
        pwm_ref = 3'h0;
        fault_level = 6'h00;
        rd_q = 1'b0;
        look = 1'b0;
        meas = 32'h0000_0000;
        failures = 0;
        total_checks = 0;
        void'($urandom(60343));
        do_reset();
        // reset values and word map of the channel registers
        rd32(8'h8c, 32'h0000_0007);
        rd32(8'h84, 32'h0000_0000);
        dt = 8'($urandom);
        wr32(8'h84, fp(1'b1, 1'b1, 1'b0, dt));
        wr32(8'h88, fp(1'b0, 1'b0, 1'b1, ~dt));
        rd32(8'h84, fp(1'b1, 1'b1, 1'b0, dt));
        rd32(8'h88, fp(1'b0, 1'b0, 1'b1, ~dt));
        rd32(8'h70, 32'h0000_0000);
        $display("test registers done");
        // run and idle drive of pair two, off-state bits from its own word
        for (int i = 0; i < 5; i++) begin
            wr32(8'h84, fp(1'b1, md[i][5], md[i][4], 8'h00));
            wr32(8'h20, {28'h0, md[i][7:6], 2'b00});
            wr32(8'h44, cm(md[i][8], 1'b0, 2'h0, 8'h00));
            repeat (4) @(posedge clk);
            probe(2'd1, {28'h0, md[i][3:0]});
        end
        $display("test modes done");
        // dead time from the common word first, then every private code range
        wr32(8'h20, 32'h0000_000c);
        wr32(8'h44, cm(1'b1, 1'b0, 2'h0, 8'h03));
        for (int i = 0; i < 6; i++) begin
            dt = (i == 5) ? 8'($urandom_range(0, 127)) : codes[i];
            wr32(8'h84, fp(i != 0, 1'b0, 1'b0, dt));
            repeat (20) @(posedge clk);
            for (int e = 0; e < 2; e++) begin
                @(posedge clk);
                pwm_ref[1] <= (e == 0);
                n = 0;
                do begin
                    @(posedge clk);
                    n++;
                    #1;
                end while (((e == 0) ? pair_out[1].direct_out : pair_out[1].compl_out) !== 1'b1 && n < 2000);
                meas = 32'(n);
                probe(2'd3, 32'(((i == 0) ? 3 : dt_len(dt)) + 2));
            end
        end
        $display("test dead time done");
        // each break source alone, beside random levels on disabled ones
        cfg = 32'h0000_0000;
        for (int s = 0; s < 6; s++) begin
            for (int k = 0; k < 2; k++) begin
                inv = (s == 3) ? 1'b0 : 1'($urandom);
                pol = 1'($urandom);
                lvl = 1'($urandom);
                cfg = 32'h0000_0000;
                cfg[en_pos[s]] = 1'b1;
                cfg[inv_pos[s]] = inv;
                wr32(8'h8c, cfg);
                rd32(8'h8c, cfg);
                wr32(8'h44, cm(1'b0, pol, 2'h0, 8'h00));
                noise = 6'($urandom);
                noise[src_bit[s]] = lvl;
                fault_level <= noise;
                repeat (3) @(posedge clk);
                probe(2'd2, {31'h0, ((s == 3) ? lvl : ((lvl ^ inv) == pol))});
            end
        end
        $display("test break done");
        // lock level one freezes select, dead time and break setup only
        wr32(8'h84, fp(1'b1, 1'b0, 1'b0, 8'h22));
        wr32(8'h44, cm(1'b0, 1'b0, 2'h1, 8'h00));
        wr32(8'h84, fp(1'b0, 1'b1, 1'b1, 8'h55));
        wr32(8'h8c, 32'h0000_0000);
        rd32(8'h84, fp(1'b1, 1'b1, 1'b1, 8'h22));
        rd32(8'h8c, cfg);
        // higher lock levels also freeze the off-state bits
        for (int lk = 2; lk < 4; lk++) begin
            do_reset();
            wr32(8'h44, cm(1'b0, 1'b0, 2'(lk), 8'h00));
            wr32(8'h88, fp(1'b0, 1'b1, 1'b1, 8'h00));
            rd32(8'h88, 32'h0000_0000);
        end
        $display("test locks done");
        complete_run();
    end
endmodule
